//--- src/lstx_pkg.sv
// Purpose: Shared constants and types for the serial transmitter clocking block
// Assumes: ref_clk runs at eight sub-steps per serial bit
// Notes: Eight sub-steps give the 45-degree phase grain at divide factor one
package lstx_pkg;
    localparam int OVS = 8;
    // Wide enough to hold the divide-by-eight period of 64 sub-steps
    localparam int OC_CNT_W = 7;
    localparam int REF_CLK_PERIOD_PS = 4000;
    localparam int PLL_LOCK_TIME_NS = 400;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_TIME_NS * 1000 + REF_CLK_PERIOD_PS - 1)
        / REF_CLK_PERIOD_PS;
    localparam int LOCK_CNT_W = 12;
    localparam int FIFO_DEPTH = 16;
    localparam logic [1:0] DIV_BY_1 = 2'h0;
    localparam logic [1:0] DIV_BY_2 = 2'h1;
    localparam logic [1:0] DIV_BY_4 = 2'h2;
    localparam logic [1:0] DIV_BY_8 = 2'h3;
    localparam logic [2:0] PHASE_EDGE_ALIGNED = 3'h0;

    typedef enum logic [1:0] {
        PLL_RESET,
        PLL_ACQUIRE,
        PLL_LOCKED
    } lstx_pll_t;
endpackage : lstx_pkg

//--- src/lstx_fifo.sv
// Purpose: Word FIFO between the feeding logic and the serializer
// Assumes: One clock; DEPTH a power of two
// Notes: Flags are registered so ready and valid leave flip-flops
`timescale 1ns/1ps
module lstx_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
            $error("lstx_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= next_count;
            in_ready <= next_count != DEPTH[AW:0];
            out_valid <= next_count != '0;
        end
    end
endmodule : lstx_fifo

//--- src/lstx_top.sv
// Purpose: Multi-channel serializer with forwarded clock, core clock and lock
// Assumes: ref_clk is the sub-step clock, OVS cycles per serial bit
// Notes: PLL is modelled as a lock timer behind pll_areset
`timescale 1ns/1ps
module lstx_top
    import lstx_pkg::*;
#(
    parameter int NUM_CH = 8,
    parameter int SER = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pll_areset,
    input wire logic lock_en,
    input wire logic [1:0] div_sel,
    input wire logic [2:0] phase_sel,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic [NUM_CH*SER-1:0] word_data,
    output logic [NUM_CH-1:0] tx_serial,
    output logic out_clk,
    output logic core_clk,
    output logic tx_locked,
    output logic rx_locked
);
    localparam int WORD_CYC = SER * OVS;
    localparam int HALF_CYC = WORD_CYC / 2;
    localparam int BIT_W = $clog2(SER);
    localparam int POS_W = $clog2(WORD_CYC);

    initial begin
        if (NUM_CH < 1 || SER < 2 || SER > 16) begin
            $error("lstx_top: NUM_CH must be at least 1 and SER within 2..16");
        end
    end

    lstx_pll_t pll_state;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic run;
    logic [2:0] sub_cnt;
    logic [BIT_W-1:0] bit_cnt;
    logic [OC_CNT_W-1:0] oc_cnt;
    logic [OC_CNT_W-1:0] oc_period;
    logic [OC_CNT_W-1:0] oc_mask;
    logic [OC_CNT_W-1:0] ph_off;
    logic [OC_CNT_W-1:0] oc_pos;
    logic [POS_W-1:0] word_pos;
    logic bit_edge;
    logic word_edge;
    logic f_valid;
    logic [NUM_CH*SER-1:0] f_data;
    logic [NUM_CH-1:0] msb_vec;

    // PLL lock timer, reset without the clock
    always_ff @(posedge ref_clk or negedge rst_n or posedge pll_areset) begin
        if (!rst_n || pll_areset) begin
            pll_state <= PLL_RESET;
            lock_cnt <= '0;
        end else begin
            unique case (pll_state)
                PLL_RESET: begin
                    pll_state <= PLL_ACQUIRE;
                    lock_cnt <= '0;
                end
                PLL_ACQUIRE: begin
                    lock_cnt <= lock_cnt + 1'b1;
                    if (lock_cnt == LOCK_CNT_W'(PLL_LOCK_CYC - 1)) begin
                        pll_state <= PLL_LOCKED;
                    end
                end
                PLL_LOCKED: begin
                    lock_cnt <= lock_cnt;
                end
            endcase
        end
    end

    assign run = pll_state == PLL_LOCKED;

    // Lock seen by both ends comes from one term
    always_ff @(posedge ref_clk or negedge rst_n or posedge pll_areset) begin
        if (!rst_n || pll_areset) begin
            tx_locked <= 1'b0;
            rx_locked <= 1'b0;
        end else begin
            tx_locked <= lock_en && run;
            rx_locked <= lock_en && run;
        end
    end

    // Sub-step, bit and forwarded clock counters
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_cnt <= '0;
            bit_cnt <= '0;
            oc_cnt <= '0;
        end else if (!run) begin
            sub_cnt <= '0;
            bit_cnt <= '0;
            oc_cnt <= '0;
        end else begin
            sub_cnt <= sub_cnt + 1'b1;
            oc_cnt <= oc_cnt + 1'b1;
            if (sub_cnt == 3'(OVS - 1)) begin
                bit_cnt <= (bit_cnt == BIT_W'(SER - 1)) ? '0 : bit_cnt + 1'b1;
            end
        end
    end

    assign bit_edge = run && sub_cnt == '0;
    assign word_edge = bit_edge && bit_cnt == '0;
    assign word_pos = POS_W'(bit_cnt) * POS_W'(OVS) + POS_W'(sub_cnt);

    // Only powers 1, 2, 4, 8 can be selected
    assign oc_period = OC_CNT_W'(OVS) << div_sel;
    assign oc_mask = oc_period - 1'b1;
    assign ph_off = OC_CNT_W'(phase_sel) << div_sel;
    assign oc_pos = (oc_cnt - ph_off) & oc_mask;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_clk <= 1'b0;
        end else begin
            out_clk <= run && oc_pos < (oc_period >> 1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_clk <= 1'b0;
        end else begin
            core_clk <= run && word_pos < POS_W'(HALF_CYC);
        end
    end

    lstx_fifo #(
        .WIDTH(NUM_CH * SER),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(word_valid),
        .in_ready(word_ready),
        .in_data(word_data),
        .out_valid(f_valid),
        .out_ready(word_edge),
        .out_data(f_data)
    );

    // Per-channel shifter, loaded on the same edge the forwarded clock rises when phase_sel is PHASE_EDGE_ALIGNED
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        logic [SER-1:0] shreg;
        assign msb_vec[c] = f_data[c*SER + SER - 1];
        assign tx_serial[c] = shreg[SER-1];
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                shreg <= '0;
            end else if (word_edge) begin
                shreg <= f_valid ? f_data[c*SER +: SER] : '0;
            end else if (bit_edge) begin
                shreg <= {shreg[SER-2:0], 1'b0};
            end
        end
    end

    // Checking helpers
    logic run_q;
    logic pulse_full;
    logic [OC_CNT_W:0] hi_cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            pulse_full <= 1'b0;
            hi_cnt <= '0;
        end else begin
            run_q <= run;
            if (!out_clk) begin
                hi_cnt <= '0;
                pulse_full <= run_q;
            end else begin
                hi_cnt <= hi_cnt + 1'b1;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking

    property p_div_legal;
        disable iff (!rst_n || pll_areset)
        run |-> (oc_period == 7'h08 || oc_period == 7'h10 || oc_period == 7'h20
            || oc_period == 7'h40);
    endproperty
    a_div_legal: assert property (p_div_legal) else $error("illegal divide");

    property p_out_clk_high;
        disable iff (!rst_n || pll_areset || !run)
        $fell(out_clk) && pulse_full && $stable(div_sel) |->
            hi_cnt == {1'b0, oc_period >> 1};
    endproperty
    a_out_clk_high: assert property (p_out_clk_high) else $error("outclk width");

    property p_phase;
        disable iff (!rst_n || pll_areset)
        $past(run, 2) && $rose(out_clk) && $stable(phase_sel) && $stable(div_sel) |->
            ((($past(oc_cnt) - ph_off) & oc_mask) == '0);
    endproperty
    a_phase: assert property (p_phase) else $error("outclk phase");

    property p_lock_follow;
        disable iff (!rst_n || pll_areset)
        (lock_en && run) ##1 (lock_en && run) |-> tx_locked;
    endproperty
    a_lock_follow: assert property (p_lock_follow) else $error("lock missing");

    property p_lock_off;
        disable iff (!rst_n)
        !lock_en |=> !tx_locked && !rx_locked;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("lock shown disabled");

    property p_shared_lock;
        disable iff (!rst_n)
        tx_locked == rx_locked;
    endproperty
    a_shared_lock: assert property (p_shared_lock) else $error("lock mismatch");

    property p_edge_aligned;
        disable iff (!rst_n || pll_areset)
        $rose(out_clk) && phase_sel == PHASE_EDGE_ALIGNED && $stable(phase_sel)
            |-> $past(bit_edge);
    endproperty
    a_edge_aligned: assert property (p_edge_aligned) else $error("data not aligned");

    property p_core_clk;
        disable iff (!rst_n || pll_areset || !run)
        $rose(core_clk) |-> ##HALF_CYC !core_clk ##HALF_CYC core_clk;
    endproperty
    a_core_clk: assert property (p_core_clk) else $error("core clock period");

    property p_pll_reset;
        disable iff (!rst_n)
        pll_areset |=> !tx_locked && !out_clk && !core_clk;
    endproperty
    a_pll_reset: assert property (p_pll_reset) else $error("pll reset ignored");

    property p_msb_first;
        disable iff (!rst_n || pll_areset)
        word_edge && f_valid |=> tx_serial == $past(msb_vec);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not first");
endmodule : lstx_top

//--- testbench/lstx_rx_model.sv
// Purpose: Far-end receiver model recovering words from the serial lanes
// Assumes: Eight ref_clk cycles per bit; core_clk rises with each first bit
// Notes: Samples mid-bit, strobes one word per core_clk period
`timescale 1ns/1ps
module lstx_rx_model #(
    parameter int NUM_CH = 8,
    parameter int SER = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [NUM_CH-1:0] tx_serial,
    input wire logic core_clk,
    output logic rx_stb,
    output logic [NUM_CH*SER-1:0] rx_word
);
    logic core_q;
    int cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_q <= 1'b0;
            cnt <= 0;
            rx_stb <= 1'b0;
            rx_word <= '0;
        end else begin
            core_q <= core_clk;
            cnt <= (core_clk && !core_q) ? 1 : cnt + 1;
            rx_stb <= (cnt == (SER - 1) * 8 + 3);
            if ((cnt % 8) == 3 && cnt < SER * 8) begin
                // Mid-bit sample, first bit lands in the top position
                for (int c = 0; c < NUM_CH; c++) begin
                    rx_word[c*SER +: SER] <= {rx_word[c*SER +: SER-1], tx_serial[c]};
                end
            end
        end
    end
endmodule : lstx_rx_model

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the serializer clocking block
// Assumes: NUM_CH=8, SER=8
// Notes: Every path ends in stop_test
`timescale 1ns/1ps
module tb_top
    import lstx_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pll_areset = 1'b0;
    logic lock_en = 1'b1;
    logic word_valid = 1'b0;
    logic [1:0] div_sel = DIV_BY_4;
    logic [2:0] phase_sel = PHASE_EDGE_ALIGNED;
    logic [63:0] word_data = 64'h0;
    logic word_ready, out_clk, core_clk, tx_locked, rx_locked, rx_stb;
    logic [7:0] tx_serial;
    logic [63:0] rx_word;
    logic [63:0] sent[$];
    logic [63:0] got[$];
    int n_errors = 0;
    int n_checks = 0;
    int n_idle = 0;
    int n;

    always #2 ref_clk = ~ref_clk;

    lstx_top #(.NUM_CH(8), .SER(8), .DEPTH(FIFO_DEPTH)) u_lstx_top (
        .ref_clk(ref_clk), .rst_n(rst_n), .pll_areset(pll_areset), .lock_en(lock_en),
        .div_sel(div_sel), .phase_sel(phase_sel), .word_valid(word_valid),
        .word_ready(word_ready), .word_data(word_data), .tx_serial(tx_serial),
        .out_clk(out_clk), .core_clk(core_clk), .tx_locked(tx_locked), .rx_locked(rx_locked)
    );
    lstx_rx_model #(.NUM_CH(8), .SER(8)) u_lstx_rx_model (
        .ref_clk(ref_clk), .rst_n(rst_n), .tx_serial(tx_serial), .core_clk(core_clk),
        .rx_stb(rx_stb), .rx_word(rx_word)
    );

    // Idle words arrive as zeros and are only counted
    always @(posedge ref_clk) begin
        if (rx_stb === 1'b1 && rx_word !== 64'h0) got.push_back(rx_word);
        else if (rx_stb === 1'b1) n_idle++;
    end

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    task automatic stop_test;
        $display("checks=%0d errors=%0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    function automatic logic pick(input bit core);
        return core ? core_clk : out_clk;
    endfunction : pick

    // Edges from a rise of clock sa to the next rise of clock sb, which may be the same clock
    task automatic gap(input bit sa, input bit sb, output int g);
        logic pa, pb, nb;
        g = -1;
        pa = pick(sa);
        nb = pick(sb);
        pb = nb;
        for (int k = 0; k < 300 && g < 0; k++) begin
            @(posedge ref_clk);
            #1;
            pb = nb;
            nb = pick(sb);
            if (pick(sa) && !pa) g = 0;
            pa = pick(sa);
        end
        if (sa == sb || !(nb && !pb)) begin
            for (int k = 0; k < 300; k++) begin
                @(posedge ref_clk);
                #1;
                g++;
                if (pick(sb) && !nb) break;
                nb = pick(sb);
            end
        end
    endtask : gap

    task automatic wait_lock;
        int k;
        k = 0;
        while (tx_locked !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        cmp(64'(k >= PLL_LOCK_CYC && k <= PLL_LOCK_CYC + 4), 64'h1);
        cmp(64'(rx_locked), 64'(tx_locked));
    endtask : wait_lock

    task automatic relock(input logic [1:0] d, input logic [2:0] p);
        @(posedge ref_clk);
        pll_areset <= 1'b1;
        div_sel <= d;
        phase_sel <= p;
        #1;
        cmp(64'({tx_locked, rx_locked}), 64'h0);
        @(posedge ref_clk);
        pll_areset <= 1'b0;
        wait_lock();
    endtask : relock

    task automatic t_lock;
        @(posedge ref_clk);
        lock_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        cmp(64'({tx_locked, rx_locked}), 64'h0);
        @(posedge ref_clk);
        lock_en <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        cmp(64'({tx_locked, rx_locked}), 64'h3);
        $display("test lock done");
    endtask : t_lock

    task automatic t_data;
        logic [63:0] d;
        int refused;
        refused = 0;
        @(posedge ref_clk);
        for (int i = 0; i < 20; i++) begin
            d = 64'h0123456789abcdef ^ {8{8'(i)}};
            word_valid <= 1'b1;
            word_data <= d;
            @(posedge ref_clk);
            while (word_ready !== 1'b1) begin
                refused++;
                @(posedge ref_clk);
            end
            sent.push_back(d);
        end
        word_valid <= 1'b0;
        cmp(64'(refused > 0), 64'h1);
        n = 0;
        while (got.size() < 20 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        n_idle = 0;
        repeat (200) @(posedge ref_clk);
        cmp(64'(n_idle > 0), 64'h1);
        cmp(64'(got.size()), 64'd20);
        foreach (sent[i]) cmp(got[i], sent[i]);
        $display("test data done");
    endtask : t_data

    task automatic t_div;
        for (int d = 0; d < 4; d++) begin
            relock(2'(d), PHASE_EDGE_ALIGNED);
            gap(1'b0, 1'b0, n);
            cmp(64'(n), 64'(8 << d));
            gap(1'b1, 1'b1, n);
            cmp(64'(n), 64'd64);
        end
        $display("test div done");
    endtask : t_div

    task automatic t_phase;
        for (int p = 0; p < 8; p++) begin
            relock(DIV_BY_1, 3'(p));
            gap(1'b1, 1'b0, n);
            cmp(64'(n), 64'(p));
        end
        $display("test phase done");
    endtask : t_phase

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_lock();
        t_lock();
        t_data();
        t_div();
        t_phase();
        stop_test();
    end

    initial begin
        #200000;
        n_errors++;
        stop_test();
    end
endmodule : tb_top
